// ---- rtl/irq_bank_pkg.sv ----
// Constants shared by the interrupt flag and enable bank
package irq_bank_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int STS_W = 3;

	// Register map, word addresses on the register port
	localparam logic [3:0] OFS_PEND2 = 4'h0;
	localparam logic [3:0] OFS_PEND3 = 4'h1;
	localparam logic [3:0] OFS_PEND4 = 4'h2;
	localparam logic [3:0] OFS_EN0 = 4'h3;
	localparam logic [3:0] OFS_EN1 = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
	localparam logic [3:0] OFS_IRQ_CLEAR = 4'h6;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h7;

	localparam logic [15:0] RESET_VALUE = 16'h0000;
	localparam logic [2:0] STS_RESET = 3'h0;

	// Implemented bit positions of each register
	localparam logic [15:0] MASK_PEND2 = 16'h0007;
	localparam logic [15:0] MASK_PEND3 = 16'h39ff;
	localparam logic [15:0] MASK_PEND4 = 16'h00f6;
	localparam logic [15:0] MASK_EN0 = 16'h7fff;
	localparam logic [15:0] MASK_EN1 = 16'hfff0;

	// Pending group two
	localparam int BIT_CAN1_RX_READY = 2;
	localparam int BIT_SPI_PORT2_EVENT = 1;
	localparam int BIT_SPI_PORT2_ERROR = 0;
	// Pending group three
	localparam int BIT_DMA_CH5_DONE = 13;
	localparam int BIT_CODEC_IF_EVENT = 12;
	localparam int BIT_CODEC_IF_ERROR = 11;
	localparam int BIT_CAN2_EVENT = 8;
	localparam int BIT_CAN2_RX_READY = 7;
	localparam int BIT_EXT_PIN4 = 6;
	localparam int BIT_EXT_PIN3 = 5;
	localparam int BIT_TIMER9 = 4;
	localparam int BIT_TIMER8 = 3;
	localparam int BIT_I2C_PORT2_MASTER = 2;
	localparam int BIT_I2C_PORT2_SLAVE = 1;
	localparam int BIT_TIMER7 = 0;
	// Pending group four
	localparam int BIT_CAN2_TX_REQUEST = 7;
	localparam int BIT_CAN1_TX_REQUEST = 6;
	localparam int BIT_DMA_CH7_DONE = 5;
	localparam int BIT_DMA_CH6_DONE = 4;
	localparam int BIT_UART_PORT2_ERROR = 2;
	localparam int BIT_UART_PORT1_ERROR = 1;

	// Enable group zero
	localparam int BIT_DMA_CH1_DONE_EN = 14;
	localparam int BIT_ADC1_DONE_EN = 13;
	localparam int BIT_UART_PORT1_TX_EN = 12;
	localparam int BIT_UART_PORT1_RX_EN = 11;
	localparam int BIT_SPI_PORT1_EVENT_EN = 10;
	localparam int BIT_SPI_PORT1_ERROR_EN = 9;
	localparam int BIT_TIMER3_EN = 8;
	localparam int BIT_TIMER2_EN = 7;
	localparam int BIT_COMPARE_CH2_EN = 6;
	localparam int BIT_CAPTURE_CH2_EN = 5;
	localparam int BIT_DMA_CH0_DONE_EN = 4;
	localparam int BIT_TIMER1_EN = 3;
	localparam int BIT_COMPARE_CH1_EN = 2;
	localparam int BIT_CAPTURE_CH1_EN = 1;
	localparam int BIT_EXT_PIN0_EN = 0;
	// Enable group one, upper part held here
	localparam int BIT_UART_PORT2_TX_EN = 15;
	localparam int BIT_UART_PORT2_RX_EN = 14;
	localparam int BIT_EXT_PIN2_EN = 13;
	localparam int BIT_TIMER5_EN = 12;
	localparam int BIT_TIMER4_EN = 11;
	localparam int BIT_COMPARE_CH4_EN = 10;
	localparam int BIT_COMPARE_CH3_EN = 9;
	localparam int BIT_DMA_CH2_DONE_EN = 8;
	localparam int BIT_CAPTURE_CH8_EN = 7;
	localparam int BIT_CAPTURE_CH7_EN = 6;
	localparam int BIT_ADC2_DONE_EN = 5;
	localparam int BIT_EXT_PIN1_EN = 4;

	// Summary status bits, one per pending group
	localparam int STS_PEND2 = 0;
	localparam int STS_PEND3 = 1;
	localparam int STS_PEND4 = 2;
endpackage

// ---- rtl/irq_flag_reg.sv ----
// One 16-bit flag or enable register with hardware set and software write
`timescale 1ns/1ps
module irq_flag_reg #(
	parameter logic [15:0] IMPL_MASK = 16'hffff
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_wr,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_wdata,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_set,
	output logic [irq_bank_pkg::DATA_W-1:0] o_value
);
	import irq_bank_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] value;
	} flag_state_t;

	flag_state_t state_q;
	flag_state_t state_d;

	always_comb begin
		state_d = state_q;
		if (i_wr) begin
			state_d.value = i_wdata;
		end
		// Set applied after the write so an event in the write cycle survives
		state_d.value = (state_d.value | i_set) & IMPL_MASK;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_q.value <= RESET_VALUE;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_value = state_q.value;
endmodule // irq_flag_reg

// ---- rtl/irq_flag_enable_bank.sv ----
// Interrupt pending flags for groups two to four and enables for groups zero and one
`timescale 1ns/1ps
module irq_flag_enable_bank (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [irq_bank_pkg::ADDR_W-1:0] i_addr,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [irq_bank_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_can1_rx_ready_flag,
	input wire logic i_spi_port2_event_flag,
	input wire logic i_spi_port2_error_flag,
	input wire logic i_dma_ch5_done_flag,
	input wire logic i_codec_if_event_flag,
	input wire logic i_codec_if_error_flag,
	input wire logic i_can2_event_flag,
	input wire logic i_can2_rx_ready_flag,
	input wire logic i_ext_pin4_flag,
	input wire logic i_ext_pin3_flag,
	input wire logic i_timer9_flag,
	input wire logic i_timer8_flag,
	input wire logic i_i2c_port2_master_flag,
	input wire logic i_i2c_port2_slave_flag,
	input wire logic i_timer7_flag,
	input wire logic i_can2_tx_request_flag,
	input wire logic i_can1_tx_request_flag,
	input wire logic i_dma_ch7_done_flag,
	input wire logic i_dma_ch6_done_flag,
	input wire logic i_uart_port2_error_flag,
	input wire logic i_uart_port1_error_flag,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_flags_group0,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_flags_group1,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_en_group2,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_en_group3,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_en_group4,
	output logic [irq_bank_pkg::DATA_W-1:0] o_pend_group2,
	output logic [irq_bank_pkg::DATA_W-1:0] o_pend_group3,
	output logic [irq_bank_pkg::DATA_W-1:0] o_pend_group4,
	output logic [irq_bank_pkg::DATA_W-1:0] o_en_group0,
	output logic [irq_bank_pkg::DATA_W-1:0] o_en_group1,
	output logic [irq_bank_pkg::DATA_W-1:0] o_req_group0,
	output logic [irq_bank_pkg::DATA_W-1:0] o_req_group1,
	output logic [irq_bank_pkg::DATA_W-1:0] o_req_group2,
	output logic [irq_bank_pkg::DATA_W-1:0] o_req_group3,
	output logic [irq_bank_pkg::DATA_W-1:0] o_req_group4,
	output logic o_irq
);
	import irq_bank_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] req0;
		logic [DATA_W-1:0] req1;
		logic [DATA_W-1:0] req2;
		logic [DATA_W-1:0] req3;
		logic [DATA_W-1:0] req4;
		logic [STS_W-1:0] sts;
		logic [STS_W-1:0] sts_en;
		logic irq;
	} bank_state_t;

	bank_state_t state_q;
	bank_state_t state_d;

	logic [DATA_W-1:0] evt2;
	logic [DATA_W-1:0] evt3;
	logic [DATA_W-1:0] evt4;
	logic [DATA_W-1:0] pend2;
	logic [DATA_W-1:0] pend3;
	logic [DATA_W-1:0] pend4;
	logic [DATA_W-1:0] en0;
	logic [DATA_W-1:0] en1;
	logic wr_pend2;
	logic wr_pend3;
	logic wr_pend4;
	logic wr_en0;
	logic wr_en1;
	logic [STS_W-1:0] new_evt;
	logic [STS_W-1:0] sts_clr;

	// Event sources are on this clock already, so no synchronisers here
	always_comb begin
		evt2 = '0;
		evt3 = '0;
		evt4 = '0;
		evt2[BIT_CAN1_RX_READY] = i_can1_rx_ready_flag;
		evt2[BIT_SPI_PORT2_EVENT] = i_spi_port2_event_flag;
		evt2[BIT_SPI_PORT2_ERROR] = i_spi_port2_error_flag;
		evt3[BIT_DMA_CH5_DONE] = i_dma_ch5_done_flag;
		evt3[BIT_CODEC_IF_EVENT] = i_codec_if_event_flag;
		evt3[BIT_CODEC_IF_ERROR] = i_codec_if_error_flag;
		evt3[BIT_CAN2_EVENT] = i_can2_event_flag;
		evt3[BIT_CAN2_RX_READY] = i_can2_rx_ready_flag;
		evt3[BIT_EXT_PIN4] = i_ext_pin4_flag;
		evt3[BIT_EXT_PIN3] = i_ext_pin3_flag;
		evt3[BIT_TIMER9] = i_timer9_flag;
		evt3[BIT_TIMER8] = i_timer8_flag;
		evt3[BIT_I2C_PORT2_MASTER] = i_i2c_port2_master_flag;
		evt3[BIT_I2C_PORT2_SLAVE] = i_i2c_port2_slave_flag;
		evt3[BIT_TIMER7] = i_timer7_flag;
		evt4[BIT_CAN2_TX_REQUEST] = i_can2_tx_request_flag;
		evt4[BIT_CAN1_TX_REQUEST] = i_can1_tx_request_flag;
		evt4[BIT_DMA_CH7_DONE] = i_dma_ch7_done_flag;
		evt4[BIT_DMA_CH6_DONE] = i_dma_ch6_done_flag;
		evt4[BIT_UART_PORT2_ERROR] = i_uart_port2_error_flag;
		evt4[BIT_UART_PORT1_ERROR] = i_uart_port1_error_flag;
	end

	assign wr_pend2 = i_wr && (i_addr == OFS_PEND2);
	assign wr_pend3 = i_wr && (i_addr == OFS_PEND3);
	assign wr_pend4 = i_wr && (i_addr == OFS_PEND4);
	assign wr_en0 = i_wr && (i_addr == OFS_EN0);
	assign wr_en1 = i_wr && (i_addr == OFS_EN1);

	irq_flag_reg #(
		.IMPL_MASK(MASK_PEND2)
	) u_pend2 (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_wr(wr_pend2),
		.i_wdata(i_wdata),
		.i_set(evt2),
		.o_value(pend2)
	);

	irq_flag_reg #(
		.IMPL_MASK(MASK_PEND3)
	) u_pend3 (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_wr(wr_pend3),
		.i_wdata(i_wdata),
		.i_set(evt3),
		.o_value(pend3)
	);

	irq_flag_reg #(
		.IMPL_MASK(MASK_PEND4)
	) u_pend4 (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_wr(wr_pend4),
		.i_wdata(i_wdata),
		.i_set(evt4),
		.o_value(pend4)
	);

	// Enables have no hardware set path
	irq_flag_reg #(
		.IMPL_MASK(MASK_EN0)
	) u_en0 (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_wr(wr_en0),
		.i_wdata(i_wdata),
		.i_set(RESET_VALUE),
		.o_value(en0)
	);

	// Bits 3-0 of group one belong to another part of the unit and read zero here
	irq_flag_reg #(
		.IMPL_MASK(MASK_EN1)
	) u_en1 (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_wr(wr_en1),
		.i_wdata(i_wdata),
		.i_set(RESET_VALUE),
		.o_value(en1)
	);

	// A group's summary event is a flag newly rising from zero
	always_comb begin
		new_evt = '0;
		new_evt[STS_PEND2] = |(evt2 & ~pend2 & MASK_PEND2);
		new_evt[STS_PEND3] = |(evt3 & ~pend3 & MASK_PEND3);
		new_evt[STS_PEND4] = |(evt4 & ~pend4 & MASK_PEND4);
		sts_clr = '0;
		if (i_wr && (i_addr == OFS_IRQ_CLEAR)) begin
			sts_clr = i_wdata[STS_W-1:0];
		end
	end

	always_comb begin
		state_d = state_q;
		// Forwarded requests are one cycle behind the flag and enable they come from
		state_d.req0 = i_flags_group0 & en0 & MASK_EN0;
		state_d.req1 = i_flags_group1 & en1 & MASK_EN1;
		state_d.req2 = pend2 & i_en_group2 & MASK_PEND2;
		state_d.req3 = pend3 & i_en_group3 & MASK_PEND3;
		state_d.req4 = pend4 & i_en_group4 & MASK_PEND4;
		// Set beats clear so an event in the clearing cycle is kept
		state_d.sts = (state_q.sts & ~sts_clr) | new_evt;
		if (i_wr && (i_addr == OFS_IRQ_ENABLE)) begin
			state_d.sts_en = i_wdata[STS_W-1:0];
		end
		state_d.irq = |(state_d.sts & state_d.sts_en);
		// Read data stands only in the cycle after the strobe
		state_d.rdata = '0;
		if (i_rd) begin
			case (i_addr)
				OFS_PEND2: state_d.rdata = pend2;
				OFS_PEND3: state_d.rdata = pend3;
				OFS_PEND4: state_d.rdata = pend4;
				OFS_EN0: state_d.rdata = en0;
				OFS_EN1: state_d.rdata = en1;
				OFS_IRQ_STATUS: state_d.rdata = {{(DATA_W-STS_W){1'b0}}, state_q.sts};
				OFS_IRQ_ENABLE: state_d.rdata = {{(DATA_W-STS_W){1'b0}}, state_q.sts_en};
				default: state_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_q.rdata <= RESET_VALUE;
			state_q.req0 <= RESET_VALUE;
			state_q.req1 <= RESET_VALUE;
			state_q.req2 <= RESET_VALUE;
			state_q.req3 <= RESET_VALUE;
			state_q.req4 <= RESET_VALUE;
			state_q.sts <= STS_RESET;
			state_q.sts_en <= STS_RESET;
			state_q.irq <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_rdata = state_q.rdata;
	assign o_pend_group2 = pend2;
	assign o_pend_group3 = pend3;
	assign o_pend_group4 = pend4;
	assign o_en_group0 = en0;
	assign o_en_group1 = en1;
	assign o_req_group0 = state_q.req0;
	assign o_req_group1 = state_q.req1;
	assign o_req_group2 = state_q.req2;
	assign o_req_group3 = state_q.req3;
	assign o_req_group4 = state_q.req4;
	assign o_irq = state_q.irq;
endmodule // irq_flag_enable_bank

// ---- verification/irq_bank_assertions.sv ----
// Concurrent checks on the interrupt flag and enable bank ports
`timescale 1ns/1ps
module irq_bank_checker (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [irq_bank_pkg::ADDR_W-1:0] i_addr,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_timer7_flag,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_en_group3,
	input wire logic [irq_bank_pkg::DATA_W-1:0] i_flags_group0,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_rdata,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_pend_group2,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_pend_group3,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_pend_group4,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_en_group0,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_en_group1,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_req_group0,
	input wire logic [irq_bank_pkg::DATA_W-1:0] o_req_group3,
	input wire logic o_irq
);
	import irq_bank_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	pend_unimpl_zero_a: assert property (((o_pend_group2 & ~MASK_PEND2) |
		(o_pend_group3 & ~MASK_PEND3) | (o_pend_group4 & ~MASK_PEND4)) == 16'h0000)
		else $error("unimplemented flag bit set");
	en_unimpl_zero_a: assert property (((o_en_group0 & ~MASK_EN0) |
		(o_en_group1 & ~MASK_EN1)) == 16'h0000) else $error("unimplemented enable bit set");
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside read slot");
	en0_write_a: assert property (i_wr && i_addr == OFS_EN0 |=>
		o_en_group0 == ($past(i_wdata) & MASK_EN0)) else $error("enable zero write lost");
	en1_read_a: assert property (i_rd && i_addr == OFS_EN1 |=> o_rdata == o_en_group1)
		else $error("enable one read wrong");
	timer7_set_a: assert property (i_timer7_flag |=> o_pend_group3[BIT_TIMER7])
		else $error("event did not set flag");
	flag_sticky_a: assert property (o_pend_group3[BIT_TIMER7] &&
		!(i_wr && i_addr == OFS_PEND3) |=> o_pend_group3[BIT_TIMER7])
		else $error("flag dropped without software");
	// Requests restart from zero after a reset edge, so that edge has no history to follow
	req3_gate_a: assert property ($past(i_resetn) |-> o_req_group3 ==
		($past(o_pend_group3) & $past(i_en_group3) & MASK_PEND3)) else $error("group three request");
	req0_gate_a: assert property ($past(i_resetn) |-> o_req_group0 ==
		($past(i_flags_group0) & $past(o_en_group0))) else $error("group zero request");
	reset_clear_a: assert property (disable iff (1'b0) !i_resetn |=>
		o_en_group0 == 16'h0000 && o_pend_group3 == 16'h0000 && !o_irq) else $error("reset value");
endmodule // irq_bank_checker
bind irq_flag_enable_bank irq_bank_checker u_irq_bank_checker (.i_clk, .i_resetn, .i_addr,
	.i_wdata, .i_wr, .i_rd, .i_timer7_flag, .i_en_group3, .i_flags_group0, .o_rdata,
	.o_pend_group2, .o_pend_group3, .o_pend_group4, .o_en_group0, .o_en_group1,
	.o_req_group0, .o_req_group3, .o_irq);

// ---- verification/irq_event_src.sv ----
// Peripheral event source model: a one-cycle pulse on one chosen line
`timescale 1ns/1ps
module irq_event_src (
	input wire logic i_clk,
	input wire logic i_fire,
	input wire logic [4:0] i_sel,
	output logic [20:0] o_events
);
	initial o_events = 21'h000000;
	// One cycle only, a held line would keep setting the flag
	always @(posedge i_clk) begin
		o_events <= i_fire ? (21'h000001 << i_sel) : 21'h000000;
	end
endmodule // irq_event_src

// ---- verification/irq_flag_enable_bank_tb.sv ----
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
module irq_flag_enable_bank_tb;
	import irq_bank_pkg::*;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic fire = 1'b0;
	logic [4:0] sel = 5'h00;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic [15:0] i_flags_group0 = 16'h0000, i_flags_group1 = 16'h0000;
	logic [15:0] i_en_group2 = 16'h0000, i_en_group3 = 16'h0000, i_en_group4 = 16'h0000;
	logic [15:0] o_rdata, o_pend_group2, o_pend_group3, o_pend_group4, o_en_group0, o_en_group1;
	logic [15:0] o_req_group0, o_req_group1, o_req_group2, o_req_group3, o_req_group4;
	logic o_irq;
	logic [20:0] ev;
	int miscompares = 0;
	int compares = 0;
	int ev_bit [21] = '{2, 1, 0, 13, 12, 11, 8, 7, 6, 5, 4, 3, 2, 1, 0, 7, 6, 5, 4, 2, 1};
	logic [15:0] masks [5] = '{MASK_PEND2, MASK_PEND3, MASK_PEND4, MASK_EN0, MASK_EN1};

	irq_event_src u_irq_event_src (.i_clk(i_clk), .i_fire(fire), .i_sel(sel), .o_events(ev));
	irq_flag_enable_bank u_irq_flag_enable_bank (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .i_flags_group0, .i_flags_group1, .i_en_group2, .i_en_group3,
		.i_en_group4, .o_pend_group2, .o_pend_group3, .o_pend_group4, .o_en_group0,
		.o_en_group1, .o_req_group0, .o_req_group1, .o_req_group2, .o_req_group3, .o_req_group4,
		.o_irq, .i_can1_rx_ready_flag(ev[0]), .i_spi_port2_event_flag(ev[1]),
		.i_spi_port2_error_flag(ev[2]), .i_dma_ch5_done_flag(ev[3]),
		.i_codec_if_event_flag(ev[4]), .i_codec_if_error_flag(ev[5]), .i_can2_event_flag(ev[6]),
		.i_can2_rx_ready_flag(ev[7]), .i_ext_pin4_flag(ev[8]), .i_ext_pin3_flag(ev[9]),
		.i_timer9_flag(ev[10]), .i_timer8_flag(ev[11]), .i_i2c_port2_master_flag(ev[12]),
		.i_i2c_port2_slave_flag(ev[13]), .i_timer7_flag(ev[14]),
		.i_can2_tx_request_flag(ev[15]), .i_can1_tx_request_flag(ev[16]),
		.i_dma_ch7_done_flag(ev[17]), .i_dma_ch6_done_flag(ev[18]),
		.i_uart_port2_error_flag(ev[19]), .i_uart_port1_error_flag(ev[20]));

	initial forever #4 i_clk = ~i_clk;

	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("BAD at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask
	task automatic fire_ev(input int i);
		@(posedge i_clk);
		sel <= 5'(i);
		fire <= 1'b1;
		@(posedge i_clk);
		fire <= 1'b0;
		tick(2);
	endtask
	function automatic logic [3:0] ev_ofs(input int i);
		return i < 3 ? OFS_PEND2 : (i < 15 ? OFS_PEND3 : OFS_PEND4);
	endfunction

	// Watchdog against a hang; the main sequence ends far sooner
	initial begin
		#200000;
		miscompares++;
		close_out();
	end

	initial begin
		repeat (5) @(posedge i_clk);
		i_resetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd_chk(4'(i), 16'h0000);
		$display("test reset values done");
		for (int i = 0; i < 5; i++) begin
			wr(4'(i), 16'hffff);
			rd_chk(4'(i), masks[i]);
			wr(4'(i), 16'h0000);
			rd_chk(4'(i), 16'h0000);
		end
		wr(OFS_IRQ_STATUS, 16'hffff);
		rd_chk(OFS_IRQ_STATUS, 16'h0000);
		rd_chk(4'hf, 16'h0000);
		$display("test access kinds done");
		for (int i = 0; i < 21; i++) begin
			fire_ev(i);
			rd_chk(ev_ofs(i), 16'h0001 << ev_bit[i]);
			wr(ev_ofs(i), 16'h0000);
		end
		$display("test event flags done");
		wr(OFS_IRQ_CLEAR, 16'h0007);
		wr(OFS_IRQ_ENABLE, 16'h0007);
		tick(2);
		chk({15'h0000, o_irq}, 16'h0000);
		fire_ev(3);
		chk({15'h0000, o_irq}, 16'h0001);
		rd_chk(OFS_IRQ_STATUS, 16'h0002);
		wr(OFS_IRQ_CLEAR, 16'h0002);
		tick(2);
		chk({15'h0000, o_irq}, 16'h0000);
		wr(OFS_IRQ_ENABLE, 16'h0000);
		wr(OFS_PEND3, 16'h0000);
		fire_ev(3);
		chk({15'h0000, o_irq}, 16'h0000);
		rd_chk(OFS_IRQ_STATUS, 16'h0002);
		wr(OFS_IRQ_ENABLE, 16'h0007);
		tick(2);
		chk({15'h0000, o_irq}, 16'h0001);
		wr(OFS_IRQ_CLEAR, 16'h0007);
		tick(2);
		chk({15'h0000, o_irq}, 16'h0000);
		$display("test interrupt line done");
		@(posedge i_clk);
		i_en_group3 <= 16'hffff;
		i_flags_group0 <= 16'hffff;
		i_flags_group1 <= 16'h0ff0;
		i_en_group2 <= 16'hffff;
		i_en_group4 <= 16'h00f0;
		wr(OFS_PEND3, 16'h2001);
		wr(OFS_EN0, 16'h8005);
		wr(OFS_EN1, 16'hffff);
		wr(OFS_PEND2, 16'h0005);
		wr(OFS_PEND4, 16'hffff);
		tick(3);
		chk(o_req_group3, 16'h2001);
		chk(o_req_group0, 16'h0005);
		chk(o_req_group1, 16'h0ff0);
		chk(o_req_group2, 16'h0005);
		chk(o_req_group4, 16'h00f0);
		@(posedge i_clk);
		i_en_group3 <= 16'h0001;
		tick(3);
		chk(o_req_group3, 16'h0001);
		@(posedge i_clk);
		i_resetn <= 1'b0;
		@(posedge i_clk);
		i_resetn <= 1'b1;
		rd_chk(OFS_EN1, 16'h0000);
		rd_chk(OFS_PEND4, 16'h0000);
		$display("test requests and reset done");
		// Timer 7 pulse lands in the same cycle as a software write of zero
		wr(OFS_PEND3, 16'h2000);
		@(posedge i_clk);
		sel <= 5'd14;
		fire <= 1'b1;
		fork
			wr(OFS_PEND3, 16'h0000);
			begin
				@(posedge i_clk);
				fire <= 1'b0;
			end
		join
		tick(2);
		rd_chk(OFS_PEND3, 16'h0001);
		$display("test event over write done");
		close_out();
	end
endmodule // irq_flag_enable_bank_tb
